// ### core/vout_fault_pkg.sv
`default_nettype none
package vout_fault_pkg;
   // Command codes
   localparam logic [7:0] CMD_OV_ACTION = 8'h41;
   localparam logic [7:0] CMD_UV_THRESHOLD = 8'h44;
   localparam logic [7:0] CMD_UV_ACTION = 8'h45;
   // Reset values
   localparam logic [7:0] OV_ACTION_RESET = 8'h04;
   localparam logic [15:0] UV_THRESHOLD_RESET = 16'h0439;
   localparam logic [7:0] UV_ACTION_RESET = 8'h04;
   // Field positions inside an action byte
   localparam int ACTION_MSB = 7;
   localparam int ACTION_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam logic [2:0] ACTION_RO_BITS = 3'h4;
   localparam logic [2:0] RETRY_LATCH = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Trip percentages, index 0 is lowest
   localparam logic [6:0] UV_PCT_0 = 7'd85;
   localparam logic [6:0] UV_PCT_1 = 7'd88;
   localparam logic [6:0] UV_PCT_2 = 7'd90;
   localparam logic [6:0] UV_PCT_3 = 7'd92;
   localparam logic [6:0] OV_PCT_0 = 7'd108;
   localparam logic [6:0] OV_PCT_1 = 7'd110;
   localparam logic [6:0] OV_PCT_2 = 7'd112;
   localparam logic [6:0] OV_PCT_3 = 7'd115;
   localparam logic [1:0] UV_SEL_RESET = 2'h1;
   localparam logic [1:0] OV_SEL_RESET = 2'h2;
   // Switching cycles of grace for delayed shutdown
   localparam logic [2:0] GRACE_CYCLES = 3'h4;

   typedef enum logic [1:0]
   {
      ACT_IGNORE = 2'b00,
      ACT_DELAYED = 2'b01,
      ACT_SHUTDOWN = 2'b10,
      ACT_RESTART = 2'b11
   } action_t;

   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_GRACE = 2'b01,
      ST_OFF = 2'b10,
      ST_RESTART = 2'b11
   } fault_state_t;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [15:0] wdata;
   } bus_req_t;

   typedef struct packed
   {
      fault_state_t state;
      logic [2:0] grace;
      logic fault_is_uv;
   } channel_t;

   typedef struct packed
   {
      logic [7:0] ov_action;
      logic [15:0] uv_threshold;
      logic [7:0] uv_action;
      logic [1:0] uv_sel;
      channel_t chan;
      logic ov_byte_bit;
      logic vout_word_bit;
      logic ov_status_bit;
      logic uv_status_bit;
      logic alert;
      logic [15:0] rdata;
      logic [31:0] nv_image;
      logic nv_store;
      logic [1:0] sw_sync;
      logic sw_prev;
      logic [1:0] ov_sync;
      logic [1:0] uv_sync;
   } state_t;
endpackage
`default_nettype wire

// ### core/vout_ov_uv_fault_policy.sv
// Operation
// - Action byte: two-bit action code, three-bit retry code, three read-only low bits.
// - Action code 00 keeps the converter running through a fault.
// - Action code 01 waits four switching cycles, then shuts down if fault persists.
// - Action code 10 shuts down at once, then follows the retry code.
// - Action code 11 shuts down and then attempts a restart.
// - Retry code 000 keeps output off until the fault is cleared.
// - Retry code 111 repeats soft-start until off, bias loss or other fault.
// - Retry codes other than 000 or 111 are refused.
// - Under-voltage limit word is linear with exponent -10.
// - Under-voltage trip is 92, 90, 88 or 85 percent; default 88.
// - In-range limit selects the nearest fixed percentage.
// - Out-of-range limit selects the nearest extreme, with no error reported.
// - Under-voltage fault sets word bit, status bit and alert line.
// - Store-defaults copies threshold and both action bytes to non-volatile memory.
// - Over-voltage fault sets byte bit, word bit, status bit and alert line.
// - Over-voltage trip is fixed at 112 percent; 108, 110 and 115 percent are not selectable.
`timescale 1ns/1ps
`default_nettype none
module vout_ov_uv_fault_policy
   import vout_fault_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register access from the bus protocol engine
   input wire bus_req_t req,
   input wire logic store_defaults,
   input wire logic [15:0] nominal_mv,
   output logic [15:0] rdata,
   output logic write_refused,
   // Converter core
   input wire logic sw_clk,
   input wire logic ov_cmp,
   input wire logic uv_cmp,
   input wire logic fault_clear,
   input wire logic commanded_off,
   output logic converter_on,
   output logic soft_start_req,
   output logic [6:0] uv_trip_pct,
   output logic [6:0] ov_trip_pct,
   // Status and alert
   input wire logic status_clear,
   output logic ov_byte_bit,
   output logic vout_word_bit,
   output logic ov_status_bit,
   output logic uv_status_bit,
   output logic alert_line,
   // Non-volatile image
   output logic [31:0] nv_image,
   output logic nv_store
);

   state_t cur_reg;
   state_t cur_next;
   logic sw_pulse;
   logic ov_f;
   logic uv_f;
   logic fault_now;
   logic [7:0] act;
   action_t first_code;
   logic [31:0] req_mv;
   logic [31:0] nom;
   logic [31:0] cuts [3];

   function automatic logic retry_ok(input logic [7:0] b);
      retry_ok = (b[RETRY_MSB:RETRY_LSB] == RETRY_LATCH) ||
                 (b[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER);
   endfunction

   function automatic logic [7:0] action_byte(input logic [7:0] b);
      action_byte = {b[ACTION_MSB:RETRY_LSB], ACTION_RO_BITS};
   endfunction

   function automatic logic [6:0] uv_pct(input logic [1:0] s);
      case (s)
         2'h0: uv_pct = UV_PCT_0;
         2'h1: uv_pct = UV_PCT_1;
         2'h2: uv_pct = UV_PCT_2;
         default: uv_pct = UV_PCT_3;
      endcase
   endfunction

   assign sw_pulse = cur_reg.sw_sync[1] & ~cur_reg.sw_prev;
   assign ov_f = cur_reg.ov_sync[1];
   assign uv_f = cur_reg.uv_sync[1];
   assign fault_now = ov_f | uv_f;
   assign act = cur_reg.chan.fault_is_uv ? cur_reg.uv_action : cur_reg.ov_action;
   assign first_code = action_t'(ov_f ? cur_reg.ov_action[ACTION_MSB:ACTION_LSB]
                                      : cur_reg.uv_action[ACTION_MSB:ACTION_LSB]);

   // Requested trip in millivolts-times-102.4 against cut points between percentages
   assign req_mv = 32'(cur_reg.uv_threshold[14:0]) * 32'd100;
   assign nom = 32'(nominal_mv) * 32'd1024 / 32'd1000;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_cut
         // Midpoints 86.5, 89, 91 percent times ten
         localparam logic [31:0] MID = (gi == 0) ? 32'd865 : (gi == 1) ? 32'd890 : 32'd910;
         assign cuts[gi] = nom * MID / 32'd10;
      end
   endgenerate

   always_comb
   begin
      cur_next = cur_reg;
      cur_next.sw_sync = {cur_reg.sw_sync[0], sw_clk};
      cur_next.sw_prev = cur_reg.sw_sync[1];
      cur_next.ov_sync = {cur_reg.ov_sync[0], ov_cmp};
      cur_next.uv_sync = {cur_reg.uv_sync[0], uv_cmp};
      cur_next.nv_store = 1'b0;
      // Quantise threshold; negative or below range clamps low
      if (cur_reg.uv_threshold[15] || req_mv < cuts[0])
         cur_next.uv_sel = 2'h0;
      else if (req_mv < cuts[1])
         cur_next.uv_sel = 2'h1;
      else if (req_mv < cuts[2])
         cur_next.uv_sel = 2'h2;
      else
         cur_next.uv_sel = 2'h3;
      // Register writes
      if (req.wr)
      begin
         case (req.cmd)
            CMD_OV_ACTION:
               if (retry_ok(req.wdata[7:0]))
                  cur_next.ov_action = action_byte(req.wdata[7:0]);
            CMD_UV_THRESHOLD: cur_next.uv_threshold = req.wdata;
            CMD_UV_ACTION:
               if (retry_ok(req.wdata[7:0]))
                  cur_next.uv_action = action_byte(req.wdata[7:0]);
            default: ;
         endcase
      end
      case (req.cmd)
         CMD_OV_ACTION: cur_next.rdata = {8'h00, cur_reg.ov_action};
         CMD_UV_THRESHOLD: cur_next.rdata = cur_reg.uv_threshold;
         CMD_UV_ACTION: cur_next.rdata = {8'h00, cur_reg.uv_action};
         default: cur_next.rdata = 16'h0000;
      endcase
      if (store_defaults)
      begin
         cur_next.nv_image = {cur_reg.uv_threshold, cur_reg.uv_action, cur_reg.ov_action};
         cur_next.nv_store = 1'b1;
      end
      // Status flags: set wins over clear
      if (status_clear)
      begin
         cur_next.ov_byte_bit = 1'b0;
         cur_next.vout_word_bit = 1'b0;
         cur_next.ov_status_bit = 1'b0;
         cur_next.uv_status_bit = 1'b0;
         cur_next.alert = 1'b0;
      end
      if (ov_f)
      begin
         cur_next.ov_byte_bit = 1'b1;
         cur_next.vout_word_bit = 1'b1;
         cur_next.ov_status_bit = 1'b1;
         cur_next.alert = 1'b1;
      end
      if (uv_f)
      begin
         cur_next.vout_word_bit = 1'b1;
         cur_next.uv_status_bit = 1'b1;
         cur_next.alert = 1'b1;
      end
      // Fault response sequencer
      case (cur_reg.chan.state)
         ST_RUN:
            if (fault_now)
            begin
               cur_next.chan.fault_is_uv = ~ov_f;
               case (first_code)
                  ACT_IGNORE: ;
                  ACT_DELAYED:
                  begin
                     cur_next.chan.state = ST_GRACE;
                     cur_next.chan.grace = 3'h0;
                  end
                  ACT_SHUTDOWN: cur_next.chan.state = ST_OFF;
                  default: cur_next.chan.state = ST_RESTART;
               endcase
            end
         ST_GRACE:
            if (cur_reg.chan.grace == GRACE_CYCLES)
               cur_next.chan.state = fault_now ? ST_OFF : ST_RUN;
            else if (sw_pulse)
               cur_next.chan.grace = cur_reg.chan.grace + 3'h1;
         ST_OFF:
            if (act[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER && !commanded_off && !fault_now)
               cur_next.chan.state = ST_RESTART;
            else if (fault_clear && !fault_now)
               cur_next.chan.state = ST_RUN;
         ST_RESTART:
            if (!fault_now && !commanded_off)
               cur_next.chan.state = ST_RUN;
         default: cur_next.chan.state = ST_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cur_reg <= '0;
         cur_reg.ov_action <= OV_ACTION_RESET;
         cur_reg.uv_threshold <= UV_THRESHOLD_RESET;
         cur_reg.uv_action <= UV_ACTION_RESET;
         cur_reg.uv_sel <= UV_SEL_RESET;
      end
      else
         cur_reg <= cur_next;
   end

   assign rdata = cur_reg.rdata;
   assign write_refused = req.wr && (req.cmd == CMD_OV_ACTION || req.cmd == CMD_UV_ACTION)
                          && !retry_ok(req.wdata[7:0]);
   assign converter_on = (cur_reg.chan.state == ST_RUN) || (cur_reg.chan.state == ST_GRACE);
   assign soft_start_req = cur_reg.chan.state == ST_RESTART;
   assign uv_trip_pct = uv_pct(cur_reg.uv_sel);
   assign ov_trip_pct = OV_PCT_2;
   assign ov_byte_bit = cur_reg.ov_byte_bit;
   assign vout_word_bit = cur_reg.vout_word_bit;
   assign ov_status_bit = cur_reg.ov_status_bit;
   assign uv_status_bit = cur_reg.uv_status_bit;
   assign alert_line = cur_reg.alert;
   assign nv_image = cur_reg.nv_image;
   assign nv_store = cur_reg.nv_store;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence grace_run_s;
      cur_reg.chan.state == ST_GRACE && cur_reg.chan.grace == GRACE_CYCLES;
   endsequence

   refuse_retry_a: assert property (@(posedge mclk) disable iff (!reset_n)
      write_refused && req.cmd == CMD_UV_ACTION |=> cur_reg.uv_action == $past(cur_reg.uv_action))
      else $error("bad retry code accepted");
   low_bits_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.uv_action[2:0] == ACTION_RO_BITS && cur_reg.ov_action[2:0] == ACTION_RO_BITS)
      else $error("read-only bits changed");
   ignore_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_RUN && fault_now &&
      (ov_f ? cur_reg.ov_action[7:6] : cur_reg.uv_action[7:6]) == 2'b00 |=> converter_on)
      else $error("ignore action shut down");
   grace_end_a: assert property (@(posedge mclk) disable iff (!reset_n)
      grace_run_s ##0 fault_now |=> cur_reg.chan.state == ST_OFF)
      else $error("grace expiry did not shut down");
   delayed_on_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_GRACE |-> converter_on)
      else $error("delayed action stopped early");
   shut_now_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_RUN && ov_f && cur_reg.ov_action[7:6] == 2'b10
      |=> !converter_on)
      else $error("shutdown action kept running");
   uv_flags_a: assert property (@(posedge mclk) disable iff (!reset_n)
      uv_f |=> uv_status_bit && vout_word_bit && alert_line)
      else $error("uv fault flags missing");
   ov_flags_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ov_f |=> ov_byte_bit && ov_status_bit && vout_word_bit && alert_line)
      else $error("ov fault flags missing");
   store_copy_a: assert property (@(posedge mclk) disable iff (!reset_n)
      store_defaults |=> nv_store && nv_image[15:8] == $past(cur_reg.uv_action))
      else $error("store did not copy settings");
   latch_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_OFF && act[5:3] == RETRY_LATCH && !fault_clear
      |=> !converter_on)
      else $error("latched output restarted");

   sequence run_fault_s;
      cur_reg.chan.state == ST_RUN && fault_now;
   endsequence

   grace_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
      run_fault_s ##0 first_code == ACT_DELAYED |=> cur_reg.chan.state == ST_GRACE)
      else $error("delayed action did not start grace");
   grace_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_GRACE && cur_reg.chan.grace != GRACE_CYCLES && sw_pulse
      |=> cur_reg.chan.grace == $past(cur_reg.chan.grace) + 3'h1)
      else $error("grace count missed a pulse");
   shut_uv_a: assert property (@(posedge mclk) disable iff (!reset_n)
      run_fault_s ##0 first_code == ACT_SHUTDOWN |=> cur_reg.chan.state == ST_OFF)
      else $error("shutdown action did not stop");
   restart_on_a: assert property (@(posedge mclk) disable iff (!reset_n)
      run_fault_s ##0 first_code == ACT_RESTART |=> soft_start_req)
      else $error("restart action did not restart");
   restart_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_RESTART && !fault_now && !commanded_off |=> converter_on)
      else $error("restart did not resume output");
   retry_loop_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.chan.state == ST_OFF && act[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER
      && !commanded_off && !fault_now |=> soft_start_req)
      else $error("retry code did not restart");
   refuse_ov_a: assert property (@(posedge mclk) disable iff (!reset_n)
      write_refused && req.cmd == CMD_OV_ACTION
      |=> cur_reg.ov_action == $past(cur_reg.ov_action))
      else $error("bad ov retry code accepted");
   thresh_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
      req.wr && req.cmd == CMD_UV_THRESHOLD |=> cur_reg.uv_threshold == $past(req.wdata))
      else $error("threshold write lost");
   uv_clamp_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cur_reg.uv_threshold[15] |=> cur_reg.uv_sel == 2'h0)
      else $error("negative limit not clamped low");
   alert_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      alert_line && !status_clear |=> alert_line)
      else $error("alert dropped without clear");
endmodule
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
   import vout_fault_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Requests to the device
   output var bus_req_t req,
   output logic store_defaults,
   output logic [15:0] nominal_mv,
   // Answers from the device
   input wire logic [15:0] rdata,
   input wire logic write_refused
);
   initial
   begin
      req <= '{wr: 1'b0, rd: 1'b0, cmd: 8'hff, wdata: 16'h0000};
      store_defaults <= 1'b0;
      nominal_mv <= 16'd1200;
   end

   task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data, output logic refused);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: data};
      #1;
      refused = write_refused;
      @(posedge mclk);
      // Idle bus shows no stale command or data
      req <= '{wr: 1'b0, rd: 1'b0, cmd: 8'hff, wdata: ~data};
   endtask

   task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data);
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: 16'h5a5a};
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b0, cmd: 8'hff, wdata: 16'ha5a5};
      #1;
      data = rdata;
   endtask

   task automatic store();
      @(posedge mclk);
      store_defaults <= 1'b1;
      @(posedge mclk);
      store_defaults <= 1'b0;
      #1;
   endtask
endmodule
`default_nettype wire

// ### tb/vout_ov_uv_fault_policy_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vout_ov_uv_fault_policy_tb;
   import vout_fault_pkg::*;
   logic mclk = 1'b0;
   logic reset_n, sw_clk, ov_cmp, uv_cmp, fault_clear, commanded_off, status_clear;
   bus_req_t req;
   logic store_defaults, write_refused, converter_on, soft_start_req, nv_store;
   logic [15:0] nominal_mv, rdata, rd;
   logic ov_byte_bit, vout_word_bit, ov_status_bit, uv_status_bit, alert_line, refused;
   logic [6:0] uv_trip_pct, ov_trip_pct;
   logic [31:0] nv_image;
   logic [4:0] flags;
   int n_errors = 0;
   int checks_done = 0;
   logic [15:0] words [6] = '{16'hffff, 16'h0320, 16'h0439, 16'h0450, 16'h0470, 16'h07ff};
   logic [6:0] pcts [6] = '{7'd85, 7'd85, 7'd88, 7'd90, 7'd92, 7'd92};

   always #20 mclk = ~mclk;
   assign flags = {uv_status_bit, vout_word_bit, alert_line, ov_byte_bit, ov_status_bit};

   host_model host (.mclk(mclk), .req(req), .store_defaults(store_defaults),
      .nominal_mv(nominal_mv), .rdata(rdata), .write_refused(write_refused));

   vout_ov_uv_fault_policy dut (.mclk(mclk), .reset_n(reset_n), .req(req),
      .store_defaults(store_defaults), .nominal_mv(nominal_mv), .rdata(rdata),
      .write_refused(write_refused), .sw_clk(sw_clk), .ov_cmp(ov_cmp), .uv_cmp(uv_cmp),
      .fault_clear(fault_clear), .commanded_off(commanded_off),
      .converter_on(converter_on), .soft_start_req(soft_start_req),
      .uv_trip_pct(uv_trip_pct), .ov_trip_pct(ov_trip_pct), .status_clear(status_clear),
      .ov_byte_bit(ov_byte_bit), .vout_word_bit(vout_word_bit),
      .ov_status_bit(ov_status_bit), .uv_status_bit(uv_status_bit),
      .alert_line(alert_line), .nv_image(nv_image), .nv_store(nv_store));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
      host.read_reg(cmd, rd);
      chk(rd, exp);
   endtask

   task automatic sw_pulse();
      @(posedge mclk) sw_clk <= 1'b1;
      cyc(3);
      @(posedge mclk) sw_clk <= 1'b0;
      cyc(3);
   endtask

   task automatic clear_all();
      @(posedge mclk)
      begin
         fault_clear <= 1'b1;
         status_clear <= 1'b1;
      end
      @(posedge mclk)
      begin
         fault_clear <= 1'b0;
         status_clear <= 1'b0;
      end
      cyc(4);
   endtask

   task automatic stop_test();
      $display("checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      n_errors++;
      stop_test();
   end

   initial
   begin
      reset_n <= 1'b0;
      sw_clk <= 1'b0;
      ov_cmp <= 1'b0;
      uv_cmp <= 1'b0;
      fault_clear <= 1'b0;
      commanded_off <= 1'b0;
      status_clear <= 1'b0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      // Reset values and unknown command
      rd_chk(CMD_OV_ACTION, 16'h0004);
      rd_chk(CMD_UV_THRESHOLD, 16'h0439);
      rd_chk(CMD_UV_ACTION, 16'h0004);
      rd_chk(8'h46, 16'h0000);
      chk(uv_trip_pct, 88);
      chk(ov_trip_pct, 112);
      // Action byte fields, read-only low bits, bad retry codes
      host.write_reg(CMD_UV_ACTION, 16'h0043, refused);
      chk(refused, 0);
      rd_chk(CMD_UV_ACTION, 16'h0044);
      for (int r = 1; r < 7; r++)
      begin
         host.write_reg(CMD_UV_ACTION, {8'h00, 2'b10, r[2:0], 3'h4}, refused);
         chk(refused, 1);
      end
      rd_chk(CMD_UV_ACTION, 16'h0044);
      host.write_reg(CMD_OV_ACTION, 16'h00d4, refused);
      chk(refused, 1);
      rd_chk(CMD_OV_ACTION, 16'h0004);
      // Threshold quantisation at 1200 mV nominal
      for (int i = 0; i < 6; i++)
      begin
         host.write_reg(CMD_UV_THRESHOLD, words[i], refused);
         cyc(2);
         chk(uv_trip_pct, pcts[i]);
      end
      rd_chk(CMD_UV_THRESHOLD, 16'h07ff);
      // Each under-voltage action code
      for (int a = 0; a < 4; a++)
      begin
         host.write_reg(CMD_UV_ACTION, {8'h00, a[1:0], (a == 2) ? 3'h7 : 3'h0, 3'h4}, refused);
         @(posedge mclk) uv_cmp <= 1'b1;
         cyc(8);
         chk(converter_on, a < 2);
         chk(soft_start_req, a == 3);
         chk(flags, 5'b11100);
         if (a == 1)
         begin
            repeat (3) sw_pulse();
            chk(converter_on, 1);
            sw_pulse();
            cyc(4);
            chk(converter_on, 0);
         end
         @(posedge mclk)
         begin
            uv_cmp <= 1'b0;
            commanded_off <= (a == 2);
         end
         cyc(10);
         chk(converter_on, a != 1 && a != 2);
         @(posedge mclk) commanded_off <= 1'b0;
         cyc(10);
         chk(converter_on, a != 1);
         clear_all();
         chk(converter_on, 1);
         chk(flags, 5'b00000);
      end
      // Over-voltage fault with immediate shutdown
      host.write_reg(CMD_OV_ACTION, 16'h0080, refused);
      @(posedge mclk) ov_cmp <= 1'b1;
      cyc(8);
      chk(flags, 5'b01111);
      chk(converter_on, 0);
      @(posedge mclk) ov_cmp <= 1'b0;
      cyc(4);
      clear_all();
      chk(converter_on, 1);
      chk(flags, 5'b00000);
      // Store-defaults image
      host.store();
      chk(nv_store, 1);
      chk(nv_image, 32'h07ff_c484);
      stop_test();
   end
endmodule
`default_nettype wire
